// File: hdl/csk_pkg.sv
package csk_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DAT_W_DEF = 8;            // Socket data lane width
  localparam int CNT_W = 8;                // Divider and wait counter width

  // ----------------------------------------------------------------
  // Card clock divider, in system clock cycles per half period
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] FULL_HALF = 8'h01;  // Full speed half period
  localparam logic [CNT_W-1:0] SLOW_HALF = 8'h08;  // Slowed half period

  // ----------------------------------------------------------------
  // Clock-run handshake timing, in system clock cycles
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] WARN_CYC = 8'h20;   // Notice before lowering the rate
  localparam logic [CNT_W-1:0] SETTLE_CYC = 8'h04; // Line settle plus synchroniser delay

  // ----------------------------------------------------------------
  // Reset values and mode codes
  // ----------------------------------------------------------------
  localparam logic CCLK_RST = 1'b0;        // Card clock low in reset
  localparam logic CRST_N_RST = 1'b0;      // Card reset asserted after reset
  localparam logic [1:0] MODE_FULL = 2'h0; // Mode code: full speed
  localparam logic [1:0] MODE_SLOW = 2'h1; // Mode code: slowed
  localparam logic [1:0] MODE_STOP = 2'h2; // Mode code: stopped low

  // ----------------------------------------------------------------
  // Clock-run sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSK_RUN  = 4'b0001,
    CSK_WARN = 4'b0010,
    CSK_SLOW = 4'b0100,
    CSK_STOP = 4'b1000
  } csk_state_type;

endpackage : csk_pkg

// File: hdl/csk_link_if.sv
interface csk_link_if #(parameter int DAT_W = csk_pkg::DAT_W_DEF);

  // ----------------------------------------------------------------
  // Socket lines
  // ----------------------------------------------------------------
  logic cclk;                 // Card clock from the socket end
  logic crst_n;               // Card reset, active low
  logic dev_clkrun_o;         // Socket end clock-run drive value
  logic dev_clkrun_oe;        // Socket end pulls clock-run low
  logic card_clkrun_o;        // Card end clock-run drive value
  logic card_clkrun_oe;       // Card end pulls clock-run low
  logic clkrun_n;             // Resolved clock-run line, pulled up
  logic [DAT_W-1:0] dev_dat_o;  // Socket end parking value
  logic dev_dat_oe;             // Socket end drives data lines
  logic [DAT_W-1:0] card_dat_o; // Card end data value
  logic card_dat_oe;            // Card end drives data lines
  logic [DAT_W-1:0] sock_dat;   // Resolved data lines

  // ----------------------------------------------------------------
  // Wire resolution: open drain with pull-up, data lines by enable
  // ----------------------------------------------------------------
  assign clkrun_n = ~((dev_clkrun_oe & ~dev_clkrun_o) | (card_clkrun_oe & ~card_clkrun_o));
  assign sock_dat = card_dat_oe ? card_dat_o : (dev_dat_oe ? dev_dat_o : '1);

  modport dev_mp (
    output cclk, crst_n, dev_clkrun_o, dev_clkrun_oe, dev_dat_o, dev_dat_oe,
    input clkrun_n, sock_dat
  );

  modport card_mp (
    output card_clkrun_o, card_clkrun_oe, card_dat_o, card_dat_oe,
    input cclk, crst_n, clkrun_n, sock_dat
  );

endinterface : csk_link_if

// File: hdl/csk_socket_ctl.sv
module csk_socket_ctl #(
  parameter int DAT_W = csk_pkg::DAT_W_DEF
) (
  input wire logic sys_clk_in,               // System clock, 10 MHz
  input wire logic rst_n_in,                 // Synchronous reset, active low
  input wire logic slow_req_in,              // Power saving: slow the card clock
  input wire logic stop_req_in,              // Power saving: stop the card clock
  input wire logic card_reset_req_in,        // Hold the card in reset
  output logic [DAT_W-1:0] rx_dat_out,       // Card data taken at card clock rise
  output logic [1:0] clk_mode_out,           // Applied clock mode
  output logic crst_active_out,              // Card reset is asserted
  csk_link_if.dev_mp link_io                 // Socket lines
);
  import csk_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csk_state_type st_r;
  csk_state_type st_nxt;
  logic [CNT_W-1:0] div_cnt_r;
  logic [CNT_W-1:0] div_cnt_nxt;
  logic [CNT_W-1:0] wait_cnt_r;
  logic [CNT_W-1:0] wait_cnt_nxt;
  logic cclk_r;
  logic cclk_nxt;
  logic slow_r;
  logic stop_r;
  logic crst_n_r;
  logic crst_n_nxt;
  logic park_oe_r;
  logic clkrun_oe_r;
  logic clkrun_oe_nxt;
  logic clkrun_s1_r;
  logic clkrun_s2_r;
  logic [DAT_W-1:0] dat_s1_r;
  logic [DAT_W-1:0] dat_s2_r;
  logic [DAT_W-1:0] rx_dat_r;
  logic [1:0] mode_r;
  logic [CNT_W-1:0] half_m1_w;
  logic tick_w;
  logic rise_w;
  logic fall_w;
  logic apply_w;
  logic want_slow_w;
  logic want_stop_w;
  logic power_req_w;
  logic card_veto_w;
  logic settled_w;
  logic warn_done_w;
  logic hold_reset_w;

  // ----------------------------------------------------------------
  // Clock-run line and card data synchronisers
  // ----------------------------------------------------------------
  // Both arrive from outside this clock's domain
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      clkrun_s1_r <= 1'b1;
      clkrun_s2_r <= 1'b1;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
    end else begin
      clkrun_s1_r <= link_io.clkrun_n;
      clkrun_s2_r <= clkrun_s1_r;
      dat_s1_r <= link_io.sock_dat;
      dat_s2_r <= dat_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Card clock divider decode
  // ----------------------------------------------------------------
  // Half period comes from the applied mode, never the requested one
  assign half_m1_w = slow_r ? (SLOW_HALF - 8'h01) : (FULL_HALF - 8'h01);
  assign tick_w = (div_cnt_r == half_m1_w) && !stop_r;
  assign rise_w = tick_w && !cclk_r;
  assign fall_w = tick_w && cclk_r;
  // Mode changes land only at a falling edge or while parked low
  assign apply_w = fall_w || stop_r;
  assign want_slow_w = (st_r == CSK_SLOW);
  assign want_stop_w = (st_r == CSK_STOP);

  // Next divider count and clock level
  assign div_cnt_nxt = (tick_w || apply_w) ? '0 : div_cnt_r + 8'h01;
  assign cclk_nxt = stop_r ? 1'b0 : (tick_w ? ~cclk_r : cclk_r);

  // ----------------------------------------------------------------
  // Card clock generator
  // ----------------------------------------------------------------
  // Every phase is a whole half period, so no runt pulse can form
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= '0;
      cclk_r <= CCLK_RST;
      slow_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      cclk_r <= cclk_nxt;
      if (apply_w) begin
        slow_r <= want_slow_w;
        stop_r <= want_stop_w && !fall_w ? 1'b1 : want_stop_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock-run sequencer decode
  // ----------------------------------------------------------------
  assign hold_reset_w = card_reset_req_in || !crst_n_r;
  assign power_req_w = (slow_req_in || stop_req_in) && !hold_reset_w;
  assign card_veto_w = !clkrun_s2_r;
  assign settled_w = (wait_cnt_r >= SETTLE_CYC);
  assign warn_done_w = (wait_cnt_r == WARN_CYC - 8'h01);

  // Next state: warn the card, then lower; any card pull restores speed
  always_comb begin
    st_nxt = st_r;
    wait_cnt_nxt = '0;
    case (st_r)
      CSK_RUN: begin
        if (power_req_w) begin
          st_nxt = CSK_WARN;
        end
      end
      CSK_WARN: begin
        wait_cnt_nxt = wait_cnt_r + 8'h01;
        if (!power_req_w || (settled_w && card_veto_w)) begin
          st_nxt = CSK_RUN;
        end else if (warn_done_w) begin
          st_nxt = stop_req_in ? CSK_STOP : CSK_SLOW;
        end
      end
      CSK_SLOW: begin
        wait_cnt_nxt = settled_w ? wait_cnt_r : wait_cnt_r + 8'h01;
        if (!slow_req_in || stop_req_in || hold_reset_w || (settled_w && card_veto_w)) begin
          st_nxt = CSK_RUN;
        end
      end
      CSK_STOP: begin
        wait_cnt_nxt = settled_w ? wait_cnt_r : wait_cnt_r + 8'h01;
        if (!stop_req_in || hold_reset_w || (settled_w && card_veto_w)) begin
          st_nxt = CSK_RUN;
        end
      end
      default: begin
        st_nxt = CSK_RUN;
      end
    endcase
  end

  // Socket pulls clock-run low only while the clock is promised to run
  assign clkrun_oe_nxt = (st_nxt == CSK_RUN);

  // ----------------------------------------------------------------
  // Clock-run sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r <= CSK_RUN;
      wait_cnt_r <= '0;
      clkrun_oe_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      clkrun_oe_r <= clkrun_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Card reset and line parking
  // ----------------------------------------------------------------
  // Assert at once on any edge; release only with a card clock rise
  assign crst_n_nxt = card_reset_req_in ? 1'b0 : (rise_w ? 1'b1 : crst_n_r);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      crst_n_r <= CRST_N_RST;
      park_oe_r <= 1'b1;
    end else begin
      crst_n_r <= crst_n_nxt;
      park_oe_r <= !crst_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Card data capture and status
  // ----------------------------------------------------------------
  // Lines are taken at each card clock rise outside reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_dat_r <= '0;
      mode_r <= MODE_FULL;
    end else begin
      if (rise_w && crst_n_r) begin
        rx_dat_r <= dat_s2_r;
      end
      mode_r <= stop_r ? MODE_STOP : (slow_r ? MODE_SLOW : MODE_FULL);
    end
  end

  // ----------------------------------------------------------------
  // Outputs, from flip-flops except dev_clkrun_o and dev_dat_o, which are tied low
  // ----------------------------------------------------------------
  assign link_io.cclk = cclk_r;
  assign link_io.crst_n = crst_n_r;
  assign link_io.dev_clkrun_o = 1'b0;
  assign link_io.dev_clkrun_oe = clkrun_oe_r;
  assign link_io.dev_dat_o = '0;
  assign link_io.dev_dat_oe = park_oe_r;
  assign rx_dat_out = rx_dat_r;
  assign clk_mode_out = mode_r;
  assign crst_active_out = park_oe_r;

endmodule // csk_socket_ctl

// File: hdl/csk_card_end.sv
module csk_card_end #(
  parameter int DAT_W = csk_pkg::DAT_W_DEF
) (
  input wire logic sys_clk_in,             // System clock, 10 MHz
  input wire logic rst_n_in,               // Synchronous reset, active low
  input wire logic need_clk_in,            // Card wants the clock at full speed
  input wire logic [DAT_W-1:0] tx_dat_in,  // Data to launch on the socket lines
  output logic [DAT_W-1:0] rx_dat_out,     // Socket lines taken at clock rise
  output logic in_reset_out,               // Card held in reset
  output logic clk_rise_out,               // Pulse per card clock rise seen
  csk_link_if.card_mp link_io              // Socket lines
);
  import csk_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic cclk_s1_r;
  logic cclk_s2_r;
  logic cclk_s3_r;
  logic crst_s1_r;
  logic crst_s2_r;
  logic [DAT_W-1:0] dat_s1_r;
  logic [DAT_W-1:0] dat_s2_r;
  logic [DAT_W-1:0] rx_dat_r;
  logic [DAT_W-1:0] tx_dat_r;
  logic dat_oe_r;
  logic clkrun_oe_r;
  logic in_reset_r;
  logic rise_r;
  logic rise_w;
  logic live_w;

  // ----------------------------------------------------------------
  // Synchronisers for socket clock, reset and data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cclk_s1_r <= 1'b0;
      cclk_s2_r <= 1'b0;
      cclk_s3_r <= 1'b0;
      crst_s1_r <= 1'b0;
      crst_s2_r <= 1'b0;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
    end else begin
      cclk_s1_r <= link_io.cclk;
      cclk_s2_r <= cclk_s1_r;
      cclk_s3_r <= cclk_s2_r;
      crst_s1_r <= link_io.crst_n;
      crst_s2_r <= crst_s1_r;
      dat_s1_r <= link_io.sock_dat;
      dat_s2_r <= dat_s1_r;
    end
  end

  // Clock rise and live state decode
  assign rise_w = cclk_s2_r && !cclk_s3_r;
  assign live_w = crst_s2_r;

  // ----------------------------------------------------------------
  // Card interface state
  // ----------------------------------------------------------------
  // Reset clears everything and floats every card output
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !live_w) begin
      rx_dat_r <= '0;
      tx_dat_r <= '0;
      dat_oe_r <= 1'b0;
      clkrun_oe_r <= 1'b0;
    end else begin
      if (rise_w) begin
        rx_dat_r <= dat_s2_r;
        tx_dat_r <= tx_dat_in;
        dat_oe_r <= 1'b1;
      end
      clkrun_oe_r <= need_clk_in;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      in_reset_r <= 1'b1;
      rise_r <= 1'b0;
    end else begin
      in_reset_r <= !live_w;
      rise_r <= rise_w;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, from flip-flops except card_clkrun_o, which is tied low
  // ----------------------------------------------------------------
  assign link_io.card_clkrun_o = 1'b0;
  assign link_io.card_clkrun_oe = clkrun_oe_r;
  assign link_io.card_dat_o = tx_dat_r;
  assign link_io.card_dat_oe = dat_oe_r;
  assign rx_dat_out = rx_dat_r;
  assign in_reset_out = in_reset_r;
  assign clk_rise_out = rise_r;

endmodule // csk_card_end

// File: verif/csk_link_sva.sv
module csk_link_sva
  import csk_pkg::*;
#(
  parameter int DAT_W = DAT_W_DEF
) (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic cclk, // Card clock
  input wire logic crst_n, // Card reset, active low
  input wire logic dev_clkrun_o, // Socket clock-run value
  input wire logic dev_clkrun_oe, // Socket pulls clock-run
  input wire logic card_clkrun_oe, // Card pulls clock-run
  input wire logic [DAT_W-1:0] dev_dat_o, // Socket park value
  input wire logic dev_dat_oe, // Socket parks lines
  input wire logic card_dat_oe // Card drives lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Phase length tracking
  // ----------------------------------------------------------------
  logic cclk_q;
  logic [7:0] run_len;
  logic [7:0] prev_len;
  logic [7:0] oe_low_cnt;
  // Level change and saturating increments
  wire logic lvl_chg = cclk != cclk_q;
  wire logic [7:0] run_inc = run_len + {7'h00, run_len != 8'hFF};
  wire logic [7:0] oe_inc = oe_low_cnt + {7'h00, oe_low_cnt != 8'hFF};

  // Current and previous clock level lengths, time since clock-run release
  always_ff @(posedge sys_clk_in) begin
    cclk_q <= rst_n_in & cclk;
    run_len <= (!rst_n_in || lvl_chg) ? 8'h01 : run_inc;
    prev_len <= !rst_n_in ? 8'h00 : (lvl_chg ? run_len : prev_len);
    oe_low_cnt <= (!rst_n_in || dev_clkrun_oe) ? 8'h00 : oe_inc;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_card_pull;
    (card_clkrun_oe && !dev_clkrun_oe) [*3];
  endsequence
  sequence s_rate_drop;
    run_len == 8'h02 && prev_len == FULL_HALF;
  endsequence

  property p_full_high;
    $rose(cclk) && $past(cclk, 2) |=> !cclk;
  endproperty
  property p_whole_high;
    $fell(cclk) |-> run_len == FULL_HALF || run_len == SLOW_HALF;
  endproperty
  property p_park_low;
    run_len > SLOW_HALF |-> !cclk_q;
  endproperty
  property p_warn_first;
    s_rate_drop |-> oe_low_cnt >= WARN_CYC;
  endproperty
  // Once the socket pulls clock-run again, a card clock rise must follow
  property p_clkrun_pull;
    $rose(dev_clkrun_oe) |-> !dev_clkrun_o ##[1:20] $rose(cclk);
  endproperty
  property p_card_raise;
    s_card_pull |-> ##[0:8] dev_clkrun_oe;
  endproperty
  property p_rst_sync;
    $rose(crst_n) |-> $rose(cclk);
  endproperty
  property p_park_lines;
    dev_dat_oe == !crst_n && dev_dat_o == '0;
  endproperty
  property p_card_float;
    !crst_n [*5] |-> !card_dat_oe && !card_clkrun_oe;
  endproperty

  a_full_high: assert property (p_full_high) else $error("full rate high phase too long");
  a_whole_high: assert property (p_whole_high) else $error("card clock runt phase");
  a_park_low: assert property (p_park_low) else $error("card clock parked high");
  a_warn_first: assert property (p_warn_first) else $error("rate lowered without notice");
  a_clkrun_pull: assert property (p_clkrun_pull) else $error("clock idle after clock-run pull");
  a_card_raise: assert property (p_card_raise) else $error("card request ignored");
  a_rst_sync: assert property (p_rst_sync) else $error("card reset released off edge");
  a_park_lines: assert property (p_park_lines) else $error("lines not parked in reset");
  a_card_float: assert property (p_card_float) else $error("card drives in reset");
endmodule // csk_link_sva

// File: verif/cardbus_socket_clock_reset_tb_top.sv
module cardbus_socket_clock_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csk_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic slow_req_in = 1'b0;
  logic stop_req_in = 1'b0;
  logic card_reset_req_in = 1'b0;
  logic need_clk_in = 1'b0;
  logic [DAT_W_DEF-1:0] tx_dat_in = 8'hA5;
  logic [DAT_W_DEF-1:0] rx_dat_out;
  logic [DAT_W_DEF-1:0] card_rx_dat;
  logic [1:0] clk_mode_out;
  logic crst_active_out;
  logic in_reset_out;
  logic clk_rise_out;
  logic rise_a;
  int n_fail = 0;
  int samples_checked = 0;
  int per;
  csk_link_if csk_link_if_inst ();
  // Socket lines seen by the bench and the checker
  wire logic cclk = csk_link_if_inst.cclk;
  wire logic crst_n = csk_link_if_inst.crst_n;
  wire logic dev_clkrun_o = csk_link_if_inst.dev_clkrun_o;
  wire logic dev_clkrun_oe = csk_link_if_inst.dev_clkrun_oe;
  wire logic card_clkrun_oe = csk_link_if_inst.card_clkrun_oe;
  wire logic [DAT_W_DEF-1:0] dev_dat_o = csk_link_if_inst.dev_dat_o;
  wire logic dev_dat_oe = csk_link_if_inst.dev_dat_oe;
  wire logic card_dat_oe = csk_link_if_inst.card_dat_oe;
  wire logic [DAT_W_DEF-1:0] sock_dat = csk_link_if_inst.sock_dat;

  csk_socket_ctl csk_socket_ctl_inst (.sys_clk_in, .rst_n_in, .slow_req_in, .stop_req_in,
    .card_reset_req_in, .rx_dat_out, .clk_mode_out, .crst_active_out,
    .link_io(csk_link_if_inst));
  csk_card_end csk_card_end_inst (.sys_clk_in, .rst_n_in, .need_clk_in, .tx_dat_in,
    .rx_dat_out(card_rx_dat), .in_reset_out, .clk_rise_out, .link_io(csk_link_if_inst));
  csk_link_sva #(.DAT_W(DAT_W_DEF)) csk_link_sva_inst (.sys_clk_in, .rst_n_in, .cclk,
    .crst_n, .dev_clkrun_o, .dev_clkrun_oe, .card_clkrun_oe, .dev_dat_o, .dev_dat_oe,
    .card_dat_oe);

  // System clock, 100 ns period
  initial begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // Compare and timing tasks
  // ----------------------------------------------------------------
  task automatic note(input logic ok, input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    note(g === e, {7'h00, g}, {7'h00, e});
  endtask
  task automatic chk_mode(input logic [1:0] g, input logic [1:0] e);
    note(g === e, {6'h00, g}, {6'h00, e});
  endtask
  task automatic chk_dat(input logic [7:0] g, input logic [7:0] e);
    note(g === e, g, e);
  endtask
  task automatic chk_per(input int g, input int e);
    note(g == e, g[7:0], e[7:0]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Wait for a card clock level, bounded
  task automatic wait_lvl(input logic v, output int k);
    k = 0;
    while (cclk !== v && k < 400) begin
      cyc(1);
      k++;
    end
    if (k == 400) begin
      note(1'b0, 8'h00, {7'h00, v});
    end
  endtask
  // Card clock period in system cycles, from one rise to the next
  task automatic period(output int p);
    int k;
    wait_lvl(1'b0, k);
    wait_lvl(1'b1, k);
    wait_lvl(1'b0, p);
    wait_lvl(1'b1, k);
    p = p + k;
  endtask
  // System reset held four cycles, socket state checked while held
  task automatic sys_reset();
    rst_n_in = 1'b0;
    cyc(4);
    chk_bit(cclk, 1'b0);
    chk_bit(crst_n, 1'b0);
    chk_bit(dev_dat_oe, 1'b1);
    chk_dat(sock_dat, 8'h00);
    chk_bit(card_dat_oe, 1'b0);
    chk_bit(in_reset_out, 1'b1);
    chk_mode(clk_mode_out, MODE_FULL);
    rst_n_in = 1'b1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 400 cycles
  initial begin
    #(20000 * 100);
    n_fail++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_reset();
    cyc(16);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    chk_bit(crst_n, 1'b1);
    chk_dat(rx_dat_out, 8'hA5);
    chk_dat(card_rx_dat, 8'hA5);
    // At full rate the card sees a rise every other system cycle
    rise_a = clk_rise_out;
    cyc(1);
    chk_bit(clk_rise_out ^ rise_a, 1'b1);
    tx_dat_in = 8'h3C;
    cyc(12);
    chk_dat(rx_dat_out, 8'h3C);
    chk_dat(card_rx_dat, 8'h3C);
    $display("test full speed done");
    card_reset_req_in = 1'b1;
    cyc(1);
    chk_bit(crst_n, 1'b0);
    chk_bit(crst_active_out, 1'b1);
    cyc(6);
    chk_bit(card_dat_oe, 1'b0);
    chk_dat(sock_dat, 8'h00);
    chk_bit(in_reset_out, 1'b1);
    card_reset_req_in = 1'b0;
    cyc(3);
    chk_bit(crst_n, 1'b1);
    chk_bit(crst_active_out, 1'b0);
    $display("test card reset done");
    slow_req_in = 1'b1;
    cyc(2);
    chk_bit(dev_clkrun_oe, 1'b0);
    cyc(20);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    cyc(30);
    period(per);
    chk_per(per, 2 * int'(SLOW_HALF));
    chk_mode(clk_mode_out, MODE_SLOW);
    need_clk_in = 1'b1;
    cyc(12);
    slow_req_in = 1'b0;
    cyc(20);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    chk_bit(dev_clkrun_oe, 1'b1);
    chk_mode(clk_mode_out, MODE_FULL);
    $display("test slow and raise done");
    stop_req_in = 1'b1;
    cyc(60);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    chk_mode(clk_mode_out, MODE_FULL);
    need_clk_in = 1'b0;
    cyc(60);
    chk_mode(clk_mode_out, MODE_STOP);
    chk_bit(cclk, 1'b0);
    cyc(20);
    chk_bit(cclk, 1'b0);
    chk_bit(clk_rise_out, 1'b0);
    need_clk_in = 1'b1;
    cyc(8);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    stop_req_in = 1'b0;
    cyc(10);
    chk_bit(dev_clkrun_oe, 1'b1);
    need_clk_in = 1'b0;
    $display("test stop and wake done");
    slow_req_in = 1'b1;
    cyc(50);
    slow_req_in = 1'b0;
    sys_reset();
    cyc(4);
    period(per);
    chk_per(per, 2 * int'(FULL_HALF));
    $display("test reset in slow mode done");
    close_out();
  end
endmodule // cardbus_socket_clock_reset_tb_top
